// ### tcpw_defs.vh
// constants shared by the two-channel timer pwm block
`ifndef TCPW_DEFS_VH
`define TCPW_DEFS_VH
`define TCPW_CNT_W      16
`define TCPW_MOD_RST    16'hffff
`define TCPW_CNT_RST    16'h0000
`define TCPW_VAL_RST    16'h0000
`define TCPW_PRE_W      6
`define TCPW_PRE_RST    6'h00
`define TCPW_PS_RST     3'h0
`define TCPW_PS_BAD     3'h7
`define TCPW_MODE_OFF   2'h0
`define TCPW_MODE_UNBUF 2'h1
`define TCPW_MODE_BUFB  1
`define TCPW_ELS_OFF    2'h0
`define TCPW_ELS_TOG    2'h1
`define TCPW_ELS_CLR    2'h2
`define TCPW_ELS_SET    2'h3
`define TCPW_SEL_CH0    1'b0
`define TCPW_SEL_CH1    1'b1
`endif

// ### tcpw_timer.v
// two-channel 16-bit timer with unbuffered and buffered pwm output
`timescale 1ns/1ps
`include "tcpw_defs.vh"

////////////////////////////////////////////////////////////////////////
// sticky flag with two-step clear: read while set, then write zero
module tcpw_flag (
	input  wire i_clk,    // system clock
	input  wire i_rst_n,  // async reset, active low
	input  wire i_set,    // hardware event
	input  wire i_rd,     // first step: status read
	input  wire i_clr,    // second step: write zero
	input  wire i_allow,  // clearing permitted now
	output wire o_flag    // flag value
);
	reg flag_reg;  // the flag
	reg arm_reg;   // first step seen
	// set wins over clear; an event in between disarms the sequence
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			flag_reg <= 1'b0;
			arm_reg  <= 1'b0;
		end else begin
			if (i_set) begin
				flag_reg <= 1'b1;
				arm_reg  <= 1'b0;
			end else if (i_allow && i_clr && arm_reg) begin
				flag_reg <= 1'b0;
				arm_reg  <= 1'b0;
			end else if (i_allow && i_rd && flag_reg) begin
				arm_reg  <= 1'b1;
			end
		end
	end
	assign o_flag = flag_reg;
endmodule // tcpw_flag

////////////////////////////////////////////////////////////////////////
// timer top: counter, prescaler, two compare channels, pwm pins
module tcpw_timer #(
	parameter CNT_W = `TCPW_CNT_W  // counter width
) (
	input  wire             I_CLK_SYS,      // 125 MHz bus clock
	input  wire             I_RST_N,        // async reset, active low
	input  wire             I_WAIT,         // cpu in wait mode
	input  wire             I_STOP,         // cpu in stop mode
	input  wire             I_BREAK,        // debug break active
	input  wire             I_BRK_CLR_EN,   // break clear enable
	input  wire             I_CTRL_WR,      // write timer status/control
	input  wire             I_HALT_D,       // counter halt bit value
	input  wire             I_CLEAR_D,      // counter clear bit value
	input  wire [2:0]       I_PS_D,         // prescale select value
	input  wire             I_OVF_IE_D,     // overflow irq enable value
	input  wire             I_STAT_RD,      // read timer status/control
	input  wire             I_OVF_CLR,      // write zero to overflow flag
	input  wire             I_MOD_WR,       // write modulo
	input  wire [CNT_W-1:0] I_MOD_D,        // modulo value
	input  wire             I_CH0_VAL_WR,   // write channel0 value
	input  wire             I_CH1_VAL_WR,   // write channel1 value
	input  wire [CNT_W-1:0] I_VAL_D,        // channel value data
	input  wire             I_CH0_CTL_RD,   // read channel0 control
	input  wire             I_CH1_CTL_RD,   // read channel1 control
	input  wire             I_CH0_FLAG_CLR, // write zero to channel0 flag
	input  wire             I_CH1_FLAG_CLR, // write zero to channel1 flag
	input  wire [1:0]       I_CH0_MODE,     // channel0 mode select
	input  wire [1:0]       I_CH1_MODE,     // channel1 mode select
	input  wire [1:0]       I_CH0_ELS,      // channel0 edge/level
	input  wire [1:0]       I_CH1_ELS,      // channel1 edge/level
	input  wire             I_CH0_TOV,      // channel0 toggle on overflow
	input  wire             I_CH1_TOV,      // channel1 toggle on overflow
	input  wire             I_CH0_MAX,      // channel0 max duty
	input  wire             I_CH1_MAX,      // channel1 max duty
	input  wire             I_CH0_IE,       // channel0 irq enable
	input  wire             I_CH1_IE,       // channel1 irq enable
	output wire [CNT_W-1:0] O_COUNT,        // counter value
	output wire             O_HALT,         // counter halt bit
	output wire [2:0]       O_PS,           // prescale select
	output wire             O_OVF_IE,       // overflow irq enable
	output wire             O_OVF_FLAG,     // overflow flag
	output wire             O_CH0_FLAG,     // channel0 flag
	output wire             O_CH1_FLAG,     // channel1 flag
	output wire             O_ACTIVE_SEL,   // buffered: 1 = channel1 pair active
	output wire             O_IRQ_OVF,      // overflow irq request
	output wire             O_IRQ_CH0,      // channel0 irq request
	output wire             O_IRQ_CH1,      // channel1 irq request
	output wire             O_WAKE,         // wake request in wait mode
	output wire             O_CH0_PIN,      // channel0 pin level
	output wire             O_CH0_OE,       // channel0 pin driven
	output wire             O_CH1_PIN,      // channel1 pin level
	output wire             O_CH1_OE        // channel1 pin driven
);
	reg  [CNT_W-1:0]      cnt_reg;      // main counter
	reg  [CNT_W-1:0]      cnt_next;     // counter next value
	reg  [`TCPW_PRE_W-1:0] pre_reg;     // prescaler
	reg  [`TCPW_PRE_W-1:0] pre_next;    // prescaler next value
	reg  [`TCPW_PRE_W-1:0] pre_mask;    // prescaler tick mask
	reg  [CNT_W-1:0]      mod_reg;      // modulo value
	reg  [CNT_W-1:0]      val0_reg;     // channel0 compare value
	reg  [CNT_W-1:0]      val1_reg;     // channel1 compare value
	reg                   halt_reg;     // counter halt bit
	reg  [2:0]            ps_reg;       // prescale select
	reg                   ovf_ie_reg;   // overflow irq enable
	reg                   sel_reg;      // active buffered pair
	reg                   last_wr_reg;  // pair written last
	reg                   pin0_reg;     // channel0 output level
	reg                   pin1_reg;     // channel1 output level
	reg                   tick;         // counter advances this cycle
	reg                   ovf_evt;      // counter reaches modulo
	wire                  acc_ok;       // cpu accesses reach registers
	wire                  run;          // counter may advance
	wire                  clr_ok;       // flags may be cleared
	wire                  linked;       // channels linked
	wire                  ch0_on;       // channel0 in compare mode
	wire                  ch1_on;       // channel1 in compare mode
	wire [CNT_W-1:0]      cmp0;         // compare value for channel0
	wire                  cmp0_evt;     // channel0 compare event
	wire                  cmp1_evt;     // channel1 compare event

	// registers are unreachable in wait and stop
	assign acc_ok = !I_WAIT && !I_STOP;
	// counter frozen by halt, stop and break
	assign run    = !halt_reg && !I_STOP && !I_BREAK;
	assign clr_ok = !I_BREAK || I_BRK_CLR_EN;
	// buffered bit wins over the low mode bit
	assign linked = I_CH0_MODE[`TCPW_MODE_BUFB];
	assign ch0_on = I_CH0_MODE != `TCPW_MODE_OFF;
	assign ch1_on = !linked && (I_CH1_MODE == `TCPW_MODE_UNBUF);

	////////////////////////////////////////////////////////////////////
	// timer status/control bits; halt set at reset
	always @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			halt_reg   <= 1'b1;
			ps_reg     <= `TCPW_PS_RST;
			ovf_ie_reg <= 1'b0;
		end else if (I_CTRL_WR && acc_ok) begin
			halt_reg   <= I_HALT_D;
			ps_reg     <= I_PS_D;
			ovf_ie_reg <= I_OVF_IE_D;
		end
	end

	////////////////////////////////////////////////////////////////////
	// prescaler tick: low ps bits of the prescaler all ones
	always @* begin
		pre_mask = ~({`TCPW_PRE_W{1'b1}} << ps_reg);
		tick     = run && (ps_reg != `TCPW_PS_BAD) && ((pre_reg & pre_mask) == pre_mask);
		pre_next = run ? pre_reg + 1'b1 : pre_reg;
		cnt_next = cnt_reg;
		ovf_evt  = 1'b0;
		if (tick) begin
			if (cnt_reg == mod_reg) begin
				cnt_next = `TCPW_CNT_RST;  // wrap after modulo
			end else begin
				cnt_next = cnt_reg + 1'b1;
			end
			ovf_evt = (cnt_next == mod_reg);
		end
		if (I_CTRL_WR && acc_ok && I_CLEAR_D) begin
			cnt_next = `TCPW_CNT_RST;
			pre_next = `TCPW_PRE_RST;
			ovf_evt  = 1'b0;
		end
	end

	// counter and prescaler state
	always @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			cnt_reg <= `TCPW_CNT_RST;
			pre_reg <= `TCPW_PRE_RST;
		end else begin
			cnt_reg <= cnt_next;
			pre_reg <= pre_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// modulo and channel values; writes land at once
	always @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			mod_reg  <= `TCPW_MOD_RST;
			val0_reg <= `TCPW_VAL_RST;
			val1_reg <= `TCPW_VAL_RST;
		end else begin
			if (I_MOD_WR && acc_ok) begin
				mod_reg <= I_MOD_D;
			end
			if (I_CH0_VAL_WR && acc_ok) begin
				val0_reg <= I_VAL_D;
			end
			if (I_CH1_VAL_WR && acc_ok) begin
				val1_reg <= I_VAL_D;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// buffered pair tracking: last written pair takes over at overflow
	always @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			sel_reg     <= `TCPW_SEL_CH0;
			last_wr_reg <= `TCPW_SEL_CH0;
		end else if (!linked) begin
			sel_reg     <= `TCPW_SEL_CH0;
			last_wr_reg <= `TCPW_SEL_CH0;
		end else begin
			if (I_CH1_VAL_WR && acc_ok) begin
				last_wr_reg <= `TCPW_SEL_CH1;
			end else if (I_CH0_VAL_WR && acc_ok) begin
				last_wr_reg <= `TCPW_SEL_CH0;
			end
			if (ovf_evt) begin
				sel_reg <= last_wr_reg;
			end
		end
	end

	// compare on exact match of the new count only
	assign cmp0     = (linked && sel_reg) ? val1_reg : val0_reg;
	assign cmp0_evt = tick && ch0_on && (cnt_next == cmp0);
	assign cmp1_evt = tick && ch1_on && (cnt_next == val1_reg);

	////////////////////////////////////////////////////////////////////
	// pin levels: overflow toggle, compare action, max duty forcing
	always @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			pin0_reg <= 1'b0;
			pin1_reg <= 1'b0;
		end else begin
			if (!ch0_on) begin
				pin0_reg <= 1'b0;
			end else if (I_CH0_TOV && I_CH0_MAX) begin
				pin0_reg <= 1'b1;
			end else if (ovf_evt && I_CH0_TOV) begin
				pin0_reg <= !pin0_reg;
			end else if (cmp0_evt) begin
				case (I_CH0_ELS)
					`TCPW_ELS_CLR: pin0_reg <= 1'b0;
					`TCPW_ELS_SET: pin0_reg <= 1'b1;
					`TCPW_ELS_TOG: pin0_reg <= !pin0_reg;
					default:       pin0_reg <= pin0_reg;
				endcase
			end
			if (!ch1_on) begin
				pin1_reg <= 1'b0;
			end else if (I_CH1_TOV && I_CH1_MAX) begin
				pin1_reg <= 1'b1;
			end else if (ovf_evt && I_CH1_TOV) begin
				pin1_reg <= !pin1_reg;
			end else if (cmp1_evt) begin
				case (I_CH1_ELS)
					`TCPW_ELS_CLR: pin1_reg <= 1'b0;
					`TCPW_ELS_SET: pin1_reg <= 1'b1;
					`TCPW_ELS_TOG: pin1_reg <= !pin1_reg;
					default:       pin1_reg <= pin1_reg;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// status flags with two-step clearing
	tcpw_flag u_ovf_flag (
		.i_clk   (I_CLK_SYS),
		.i_rst_n (I_RST_N),
		.i_set   (ovf_evt),
		.i_rd    (I_STAT_RD && acc_ok),
		.i_clr   (I_OVF_CLR && acc_ok),
		.i_allow (clr_ok),
		.o_flag  (O_OVF_FLAG)
	);
	tcpw_flag u_ch0_flag (
		.i_clk   (I_CLK_SYS),
		.i_rst_n (I_RST_N),
		.i_set   (cmp0_evt),
		.i_rd    (I_CH0_CTL_RD && acc_ok),
		.i_clr   (I_CH0_FLAG_CLR && acc_ok),
		.i_allow (clr_ok),
		.o_flag  (O_CH0_FLAG)
	);
	tcpw_flag u_ch1_flag (
		.i_clk   (I_CLK_SYS),
		.i_rst_n (I_RST_N),
		.i_set   (cmp1_evt),
		.i_rd    (I_CH1_CTL_RD && acc_ok),
		.i_clr   (I_CH1_FLAG_CLR && acc_ok),
		.i_allow (clr_ok),
		.o_flag  (O_CH1_FLAG)
	);

	////////////////////////////////////////////////////////////////////
	// interrupt requests gated by their enables
	assign O_IRQ_OVF    = O_OVF_FLAG && ovf_ie_reg;
	assign O_IRQ_CH0    = O_CH0_FLAG && I_CH0_IE;
	assign O_IRQ_CH1    = O_CH1_FLAG && I_CH1_IE && !linked;
	assign O_WAKE       = I_WAIT && (O_IRQ_OVF || O_IRQ_CH0 || O_IRQ_CH1);
	assign O_COUNT      = cnt_reg;
	assign O_HALT       = halt_reg;
	assign O_PS         = ps_reg;
	assign O_OVF_IE     = ovf_ie_reg;
	assign O_ACTIVE_SEL = sel_reg;
	// pins driven only when the channel compares and action is chosen
	assign O_CH0_PIN    = pin0_reg;
	assign O_CH0_OE     = ch0_on && (I_CH0_ELS != `TCPW_ELS_OFF || I_CH0_TOV);
	assign O_CH1_PIN    = pin1_reg;
	assign O_CH1_OE     = ch1_on && (I_CH1_ELS != `TCPW_ELS_OFF || I_CH1_TOV);
endmodule // tcpw_timer

// ### tcpw_timer_chk.sv
// concurrent assertion checker for the two-channel timer pwm top
`timescale 1ns/1ps
module tcpw_timer_chk #(
	parameter CNT_W = 16 // counter width
) (
	input wire             I_CLK_SYS,  // system clock
	input wire             I_RST_N,    // async reset, active low
	input wire             I_WAIT,     // wait mode
	input wire             I_STOP,     // stop mode
	input wire             I_BREAK,    // debug break
	input wire             I_BRK_CLR_EN, // break clear enable
	input wire             I_CTRL_WR,  // control write strobe
	input wire             I_CLEAR_D,  // counter clear value
	input wire             I_OVF_CLR,  // overflow flag clear strobe
	input wire [1:0]       I_CH0_MODE, // channel0 mode select
	input wire [1:0]       I_CH0_ELS,  // channel0 edge/level
	input wire             I_CH0_TOV,  // channel0 toggle on overflow
	input wire             I_CH0_MAX,  // channel0 max duty
	input wire             I_CH0_IE,   // channel0 irq enable
	input wire [CNT_W-1:0] O_COUNT,    // counter value
	input wire             O_HALT,     // counter halt bit
	input wire [2:0]       O_PS,       // prescale select
	input wire             O_OVF_IE,   // overflow irq enable
	input wire             O_OVF_FLAG, // overflow flag
	input wire             O_CH0_FLAG, // channel0 flag
	input wire             O_IRQ_OVF,  // overflow irq request
	input wire             O_IRQ_CH0,  // channel0 irq request
	input wire             O_IRQ_CH1,  // channel1 irq request
	input wire             O_WAKE,     // wake request
	input wire             O_CH0_PIN,  // channel0 pin level
	input wire             O_CH1_OE    // channel1 pin driven
);
	////////////////////////////////////////////////////////////////////////
	// one clock domain: shared clocking and reset gating
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RST_N);
	// reset leaves the counter halted; checked while reset is low too
	property p_halt_rst; disable iff (1'b0) !I_RST_N |=> O_HALT; endproperty
	a_halt_rst: assert property (p_halt_rst) else $error("halt bit not set by reset");
	// halt, stop or break freeze the counter unless it is cleared
	property p_frozen; (O_HALT || I_STOP || I_BREAK) && !(I_CTRL_WR && I_CLEAR_D) |=> $stable(O_COUNT); endproperty
	a_frozen: assert property (p_frozen) else $error("counter moved while frozen");
	// divide by one: one step per running cycle
	property p_step; !O_HALT && !I_STOP && !I_BREAK && O_PS == 3'h0 && !(I_CTRL_WR && I_CLEAR_D)
		|=> O_COUNT == $past(O_COUNT) + 16'h0001 || O_COUNT == 16'h0000; endproperty
	a_step: assert property (p_step) else $error("counter step wrong");
	// the invalid prescale code never ticks
	property p_ps_bad; O_PS == 3'h7 && !I_CTRL_WR |=> $stable(O_COUNT); endproperty
	a_ps_bad: assert property (p_ps_bad) else $error("counter ticked on invalid prescale");
	// clear bit zeroes the counter on the next edge
	property p_clear; I_CTRL_WR && I_CLEAR_D && !I_WAIT && !I_STOP |=> O_COUNT == 16'h0000; endproperty
	a_clear: assert property (p_clear) else $error("counter not cleared");
	// requests are flag gated by enable
	property p_irq; O_IRQ_OVF == (O_OVF_FLAG && O_OVF_IE) && O_IRQ_CH0 == (O_CH0_FLAG && I_CH0_IE); endproperty
	a_irq: assert property (p_irq) else $error("irq request not flag and enable");
	// wake only in wait with a pending request
	property p_wake; O_WAKE == (I_WAIT && (O_IRQ_OVF || O_IRQ_CH0 || O_IRQ_CH1)); endproperty
	a_wake: assert property (p_wake) else $error("wake request wrong");
	// the overflow flag only falls after a write of zero
	property p_clr_ovf; $fell(O_OVF_FLAG) |-> $past(I_OVF_CLR); endproperty
	a_clr_ovf: assert property (p_clr_ovf) else $error("overflow flag fell without clear");
	// the protected overflow flag holds during break
	property p_brk_keep; I_BREAK && !I_BRK_CLR_EN && O_OVF_FLAG |=> O_OVF_FLAG; endproperty
	a_brk_keep: assert property (p_brk_keep) else $error("flag changed in protected break");
	// max duty with toggle on overflow drives high after a tick
	property p_max; (I_CH0_MODE != 2'h0 && I_CH0_TOV && I_CH0_MAX) ##1 (O_COUNT != $past(O_COUNT)) |-> O_CH0_PIN;
	endproperty
	a_max: assert property (p_max) else $error("max duty pin not high");
	// without overflow toggles a clearing compare never raises the pin
	property p_tov_off; !I_CH0_TOV && I_CH0_ELS == 2'h2 |=> !$rose(O_CH0_PIN); endproperty
	a_tov_off: assert property (p_tov_off) else $error("pin rose without overflow toggle");
	// linked channels free the channel1 pin and mask its request
	property p_link; I_CH0_MODE[1] |-> !O_CH1_OE && !O_IRQ_CH1; endproperty
	a_link: assert property (p_link) else $error("channel1 active while linked");
endmodule // tcpw_timer_chk

bind tcpw_timer tcpw_timer_chk #(.CNT_W(CNT_W)) i_chk (.I_CLK_SYS, .I_RST_N, .I_WAIT, .I_STOP, .I_BREAK,
	.I_BRK_CLR_EN, .I_CTRL_WR, .I_CLEAR_D, .I_OVF_CLR, .I_CH0_MODE, .I_CH0_ELS, .I_CH0_TOV, .I_CH0_MAX,
	.I_CH0_IE, .O_COUNT,
	.O_HALT, .O_PS, .O_OVF_IE, .O_OVF_FLAG, .O_CH0_FLAG, .O_IRQ_OVF, .O_IRQ_CH0, .O_IRQ_CH1, .O_WAKE,
	.O_CH0_PIN, .O_CH1_OE);

// ### test_tcpw_timer.sv
// self-checking testbench of the two-channel timer pwm block
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
	$display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module test_tcpw_timer;
	logic        clk, rst_n, wt, stp, brk, bclr; // clock, reset, modes
	logic [9:0]  stb;                            // register strobes
	logic [15:0] dat, c;                         // write data, sampled count
	logic [1:0]  m0, m1, e0, e1;                 // channel modes, edge/level
	logic        t0, t1, x0, x1, ie0, ie1;       // toggle, max duty, irq enables
	logic [7:0]  h0, h1;                         // high cycles per period
	int          fails = 0, tests_run = 0, cyc = 0; // counters
	wire  [15:0] cnt;                            // counter
	wire  [2:0]  ps;                             // prescale select
	wire         halt, ovf_ie, fo, f0, f1, sel, io, i0, i1, wake, p0, oe0, p1, oe1; // status
	tcpw_timer i_dut (
		.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_WAIT(wt), .I_STOP(stp), .I_BREAK(brk), .I_BRK_CLR_EN(bclr),
		.I_CTRL_WR(stb[0]), .I_HALT_D(dat[0]), .I_CLEAR_D(dat[1]), .I_PS_D(dat[4:2]), .I_OVF_IE_D(dat[5]),
		.I_STAT_RD(stb[1]), .I_OVF_CLR(stb[2]), .I_MOD_WR(stb[3]), .I_MOD_D(dat), .I_CH0_VAL_WR(stb[4]),
		.I_CH1_VAL_WR(stb[5]), .I_VAL_D(dat), .I_CH0_CTL_RD(stb[6]), .I_CH1_CTL_RD(stb[7]),
		.I_CH0_FLAG_CLR(stb[8]), .I_CH1_FLAG_CLR(stb[9]), .I_CH0_MODE(m0), .I_CH1_MODE(m1), .I_CH0_ELS(e0),
		.I_CH1_ELS(e1), .I_CH0_TOV(t0), .I_CH1_TOV(t1), .I_CH0_MAX(x0), .I_CH1_MAX(x1), .I_CH0_IE(ie0),
		.I_CH1_IE(ie1), .O_COUNT(cnt), .O_HALT(halt), .O_PS(ps), .O_OVF_IE(ovf_ie), .O_OVF_FLAG(fo),
		.O_CH0_FLAG(f0), .O_CH1_FLAG(f1), .O_ACTIVE_SEL(sel), .O_IRQ_OVF(io), .O_IRQ_CH0(i0), .O_IRQ_CH1(i1),
		.O_WAKE(wake), .O_CH0_PIN(p0), .O_CH0_OE(oe0), .O_CH1_PIN(p1), .O_CH1_OE(oe1));
	////////////////////////////////////////////////////////////////////////
	// 125 MHz clock and hang guard
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			fails++;
			finish_test();
		end
	end
	// one strobe for one edge, outputs settled on return
	task automatic pulse(input int i, input logic [15:0] d);
		@(posedge clk);
		stb[i] <= 1'b1;
		dat    <= d;
		@(posedge clk);
		stb[i] <= 1'b0;
		@(negedge clk);
	endtask
	// wait for a counter value, bounded
	task automatic wait_cnt(input logic [15:0] v);
		@(negedge clk);
		for (int k = 0; k < 40 && cnt !== v; k++)
			@(negedge clk);
		`CHK(cnt, v)
	endtask
	// count high cycles of both pins over one ten-cycle period
	task automatic duty(input logic [7:0] a, input logic [7:0] b);
		repeat (20) @(negedge clk);
		h0 = 8'h00;
		h1 = 8'h00;
		repeat (10) begin
			@(negedge clk);
			h0 = h0 + p0;
			h1 = h1 + p1;
		end
		`CHK(h0, a)
		`CHK(h1, b)
	endtask
	// verdict and end of run
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		clk   = 1'b0;
		rst_n = 1'b0;
		{wt, stp, brk, bclr, t0, t1, x0, x1, ie0, ie1} = 10'h000;
		{stb, dat, m0, m1, e0, e1} = 34'h0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		`CHK({halt, cnt}, 17'h10000)
		`CHK({fo, f0, f1, ps, ovf_ie}, 7'h00)
		pulse(3, 16'hffff);
		for (int p = 0; p < 8; p++) begin
			pulse(0, {11'h000, p[2:0], 2'b10});
			repeat (64) @(posedge clk);
			@(negedge clk);
			`CHK({ps, cnt}, {p[2:0], (p == 7) ? 16'h0000 : (16'h0040 >> p)})
		end
		pulse(0, 16'h0003);
		repeat (4) @(negedge clk);
		`CHK({halt, cnt}, 17'h10000)
		pulse(3, 16'h0009);
		pulse(4, 16'h0003);
		pulse(5, 16'h0005);
		@(posedge clk);
		{m0, e0, t0, ie0} <= {2'h1, 2'h2, 1'b1, 1'b1};
		{m1, e1, t1, ie1} <= {2'h1, 2'h3, 1'b1, 1'b1};
		pulse(0, 16'h0000);
		duty(8'd4, 8'd4);
		wait_cnt(16'h0003);
		`CHK({f0, i0, p0}, 3'b110)
		pulse(4, 16'h0002);
		pulse(6, 16'h0000);
		pulse(8, 16'h0000);
		`CHK(f0, 1'b0)
		wait_cnt(16'h0009);
		`CHK({fo, io, p0, f1, i1}, 5'b10111)
		pulse(2, 16'h0000);
		`CHK(fo, 1'b1)
		pulse(1, 16'h0000);
		pulse(2, 16'h0000);
		`CHK({fo, io}, 2'b00)
		pulse(7, 16'h0000);
		pulse(9, 16'h0000);
		`CHK(f1, 1'b0)
		wait_cnt(16'h0006);
		pulse(1, 16'h0000);
		wait_cnt(16'h0001);
		pulse(2, 16'h0000);
		`CHK(fo, 1'b1)
		pulse(0, 16'h0020);
		`CHK({ovf_ie, io}, 2'b11)
		@(posedge clk);
		wt <= 1'b1;
		pulse(0, 16'h0001);
		c = cnt;
		@(negedge clk);
		`CHK({halt, wake, cnt != c}, 3'b011)
		@(posedge clk);
		wt <= 1'b0;
		wait_cnt(16'h0000);
		pulse(1, 16'h0000);
		@(posedge clk);
		brk <= 1'b1;
		@(negedge clk);
		c = cnt;
		pulse(2, 16'h0000);
		`CHK({cnt, fo}, {c, 1'b1})
		@(posedge clk);
		brk <= 1'b0;
		pulse(2, 16'h0000);
		`CHK(fo, 1'b0)
		wait_cnt(16'h0000);
		@(posedge clk);
		{brk, bclr} <= 2'b11;
		pulse(1, 16'h0000);
		pulse(2, 16'h0000);
		`CHK(fo, 1'b0)
		@(posedge clk);
		{brk, bclr, stp} <= 3'b001;
		@(negedge clk);
		c = cnt;
		repeat (5) @(negedge clk);
		`CHK(cnt, c)
		@(posedge clk);
		stp <= 1'b0;
		duty(8'd3, 8'd4);
		wait_cnt(16'h0009);
		pulse(4, 16'h0007);
		duty(8'd8, 8'd4);
		wait_cnt(16'h0004);
		pulse(4, 16'h0002);
		wait_cnt(16'h0008);
		`CHK(p0, 1'b1)
		wait_cnt(16'h0000);
		`CHK(p0, 1'b0)
		@(posedge clk);
		x0 <= 1'b1;
		duty(8'd10, 8'd4);
		@(posedge clk);
		{x0, t0} <= 2'b00;
		duty(8'd0, 8'd4);
		@(posedge clk);
		{t0, m0} <= 3'b111;
		pulse(5, 16'h0006);
		pulse(4, 16'h0003);
		duty(8'd4, 8'd0);
		`CHK({sel, oe0, oe1, i1}, 4'b0100)
		wait_cnt(16'h0001);
		pulse(5, 16'h0006);
		wait_cnt(16'h0005);
		`CHK({sel, p0}, 2'b00)
		wait_cnt(16'h0000);
		`CHK(sel, 1'b1)
		@(posedge clk);
		m0 <= 2'h2;
		duty(8'd7, 8'd0);
		finish_test();
	end
endmodule // test_tcpw_timer
